// ==== include/refin_cfg.svh ====
`ifndef REFIN_CFG_SVH
`define REFIN_CFG_SVH

// ==========================================================================
// Register indexes (byte address is four times the index)
`define IDX_SRC_SEL     8'h32
`define IDX_ICC         8'h33
`define IDX_RDIV        8'h34
`define IDX_MDIV        8'h35
`define IDX_STATUS      8'h3F
`define ADDR_W          10
`define BYTE_ADDR(idx)  ({(idx), 2'b00})

// ==========================================================================
// Reset values
`define RST_SRC_SEL     2'h1
`define RST_ICC         8'h03
`define RST_RDIV        3'h0
`define RST_MDIV        5'h00

// ==========================================================================
// Field positions
`define ICC_MUX_BYP     7
`define ICC_KEEP_ON     2
`define ICC_SEC_GAIN    1
`define ICC_PRI_GAIN    0
`define RDIV_MSB        2
`define MDIV_MSB        4
`define SRC_MSB         1

// ==========================================================================
// Bus answers
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ==== include/refin_pkg.sv ====
package refin_pkg;

  // Source select modes of the first synthesizer's reference mux
  typedef enum logic [1:0] {
    SRC_AUTO = 2'h0,
    SRC_PIN  = 2'h1,
    SRC_PRI  = 2'h2,
    SRC_SEC  = 2'h3
  } src_mode_e;

  // Secondary buffer life cycle, Gray coded along the usual path
  typedef enum logic [1:0] {
    SB_STANDBY = 2'b00,
    SB_ON_SEC  = 2'b01,
    SB_BACK    = 2'b11
  } sec_buf_state_e;

  typedef struct packed {
    logic       ref_mux_bypass;
    logic [3:0] reserved;
    logic       sec_buf_keep_on;
    logic       sec_buf_gain_max;
    logic       pri_buf_gain_max;
  } input_clock_control_s;

  typedef struct packed {
    logic [3:0] ref_ratio;
    logic       ref_bypass;
    logic [5:0] m_ratio;
    logic       m_bypass;
  } divider_out_s;

endpackage

// ==== verilog/ref_input_and_synth1_divider_regs.sv ====
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`include "refin_cfg.svh"

module ref_input_and_synth1_divider_regs (
  input  wire logic                 aclk,              // System clock
  input  wire logic                 aresetn,           // Sync reset, low
  input  wire logic [`ADDR_W-1:0]   s_axi_awaddr,      // Write address
  input  wire logic                 s_axi_awvalid,     // Write addr valid
  output logic                      s_axi_awready,     // Write addr ready
  input  wire logic [31:0]          s_axi_wdata,       // Write data
  input  wire logic [3:0]           s_axi_wstrb,       // Byte enables
  input  wire logic                 s_axi_wvalid,      // Write data valid
  output logic                      s_axi_wready,      // Write data ready
  output logic [1:0]                s_axi_bresp,       // Write response
  output logic                      s_axi_bvalid,      // Response valid
  input  wire logic                 s_axi_bready,      // Response ready
  input  wire logic [`ADDR_W-1:0]   s_axi_araddr,      // Read address
  input  wire logic                 s_axi_arvalid,     // Read addr valid
  output logic                      s_axi_arready,     // Read addr ready
  output logic [31:0]               s_axi_rdata,       // Read data
  output logic [1:0]                s_axi_rresp,       // Read response
  output logic                      s_axi_rvalid,      // Read data valid
  input  wire logic                 s_axi_rready,      // Read data ready
  input  wire logic                 pri_clk_present,   // Primary ref alive
  input  wire logic                 sec_clk_present,   // Secondary alive
  input  wire logic                 ref_select_pin,    // External select
  output logic                      ref_mux_bypass,    // Mux bypass
  output logic                      sec_buf_en,        // Sec buffer power
  output logic                      sec_buf_gain_max,  // Sec gain max
  output logic                      pri_buf_gain_max,  // Pri gain max
  output logic                      ref_sel_secondary, // Mux on secondary
  output logic [3:0]                synth1_ref_ratio,  // R divide ratio
  output logic                      synth1_ref_bypass, // R divider bypass
  output logic [5:0]                synth1_m_ratio,    // M divide ratio
  output logic                      synth1_m_bypass    // M divider bypass
);

  default clocking assert_clk @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ========================================================================
  // Helpers
  function automatic logic [5:0] code_to_ratio(input logic [4:0] code);
    code_to_ratio = (code == 5'h00) ? 6'h01 : ({1'b0, code} + 6'h01);
  endfunction

  function automatic logic addr_is(input logic [`ADDR_W-1:0] a,
                                   input logic [7:0]         idx);
    addr_is = (a == `BYTE_ADDR(idx));
  endfunction

  // ========================================================================
  // Pin synchronisers: bit 0 primary, bit 1 secondary, bit 2 select pin
  logic [2:0] meta_reg, sync_reg;
  logic       pri_ok, sec_ok, pin_sel;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= {ref_select_pin, sec_clk_present, pri_clk_present};
      sync_reg <= meta_reg;
    end
  end
  assign pri_ok  = sync_reg[0];
  assign sec_ok  = sync_reg[1];
  assign pin_sel = sync_reg[2];

  // ========================================================================
  // AXI4-Lite write channel
  logic                        aw_full_reg, aw_full_next;
  logic                        w_full_reg, w_full_next;
  logic [`ADDR_W-1:0]          aw_addr_reg, aw_addr_next;
  logic [31:0]                 w_data_reg, w_data_next;
  logic                        w_strb_reg, w_strb_next;
  logic                        bvalid_reg, bvalid_next;
  logic [1:0]                  bresp_reg, bresp_next;
  logic                        aw_hs, w_hs, do_write, wr_lane0;
  logic [`ADDR_W-1:0]          wr_addr;
  logic [31:0]                 wr_data;
  logic                        wr_mapped;

  assign s_axi_awready = !aw_full_reg && !bvalid_reg;
  assign s_axi_wready  = !w_full_reg && !bvalid_reg;
  assign aw_hs         = s_axi_awvalid && s_axi_awready;
  assign w_hs          = s_axi_wvalid && s_axi_wready;
  // Either order: a held half waits for the other, then both commit
  assign do_write      = (aw_full_reg || aw_hs) && (w_full_reg || w_hs);
  assign wr_addr       = aw_full_reg ? aw_addr_reg : s_axi_awaddr;
  assign wr_data       = w_full_reg ? w_data_reg : s_axi_wdata;
  assign wr_lane0      = w_full_reg ? w_strb_reg : s_axi_wstrb[0];
  // Status is read-only; a write to it is accepted and dropped
  assign wr_mapped     = addr_is(wr_addr, `IDX_SRC_SEL) ||
                         addr_is(wr_addr, `IDX_ICC) ||
                         addr_is(wr_addr, `IDX_RDIV) ||
                         addr_is(wr_addr, `IDX_MDIV) ||
                         addr_is(wr_addr, `IDX_STATUS);

  always_comb begin
    aw_addr_next = aw_hs ? s_axi_awaddr : aw_addr_reg;
    w_data_next  = w_hs ? s_axi_wdata : w_data_reg;
    w_strb_next  = w_hs ? s_axi_wstrb[0] : w_strb_reg;
    aw_full_next = !do_write && (aw_full_reg || aw_hs);
    w_full_next  = !do_write && (w_full_reg || w_hs);
    bvalid_next  = do_write || (bvalid_reg && !s_axi_bready);
    bresp_next   = !do_write ? bresp_reg :
                   wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= 32'h0;
      w_strb_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `RESP_OKAY;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      aw_addr_reg <= aw_addr_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  // ========================================================================
  // Configuration registers
  refin_pkg::input_clock_control_s icc_reg, icc_next;
  logic [`RDIV_MSB:0]              rdiv_reg, rdiv_next;
  logic [`MDIV_MSB:0]              mdiv_reg, mdiv_next;
  refin_pkg::src_mode_e            src_reg, src_next;
  refin_pkg::divider_out_s         div_reg, div_next;
  logic                            wr_en, icc_wr, rdiv_wr, mdiv_wr;

  assign wr_en   = do_write && wr_lane0;
  assign icc_wr  = wr_en && addr_is(wr_addr, `IDX_ICC);
  assign rdiv_wr = wr_en && addr_is(wr_addr, `IDX_RDIV);
  assign mdiv_wr = wr_en && addr_is(wr_addr, `IDX_MDIV);

  always_comb begin
    icc_next  = icc_wr ? refin_pkg::input_clock_control_s'(wr_data[7:0])
                       : icc_reg;
    rdiv_next = rdiv_wr ? wr_data[`RDIV_MSB:0] : rdiv_reg;
    mdiv_next = mdiv_wr ? wr_data[`MDIV_MSB:0] : mdiv_reg;
    src_next  = src_reg;
    if (wr_en && addr_is(wr_addr, `IDX_SRC_SEL)) begin
      src_next = refin_pkg::src_mode_e'(wr_data[`SRC_MSB:0]);
    end
    div_next.ref_ratio  = 4'(code_to_ratio({2'b00, rdiv_next}));
    div_next.ref_bypass = (rdiv_next == `RST_RDIV);
    div_next.m_ratio    = code_to_ratio(mdiv_next);
    div_next.m_bypass   = (mdiv_next == `RST_MDIV);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      icc_reg  <= refin_pkg::input_clock_control_s'(`RST_ICC);
      rdiv_reg <= `RST_RDIV;
      mdiv_reg <= `RST_MDIV;
      src_reg  <= refin_pkg::src_mode_e'(`RST_SRC_SEL);
      div_reg  <= '{ref_ratio: 4'h1, ref_bypass: 1'b1,
                    m_ratio: 6'h01, m_bypass: 1'b1};
    end else begin
      icc_reg  <= icc_next;
      rdiv_reg <= rdiv_next;
      mdiv_reg <= mdiv_next;
      src_reg  <= src_next;
      div_reg  <= div_next;
    end
  end

  assign ref_mux_bypass    = icc_reg.ref_mux_bypass;
  assign sec_buf_gain_max  = icc_reg.sec_buf_gain_max;
  assign pri_buf_gain_max  = icc_reg.pri_buf_gain_max;
  assign synth1_ref_ratio  = div_reg.ref_ratio;
  assign synth1_ref_bypass = div_reg.ref_bypass;
  assign synth1_m_ratio    = div_reg.m_ratio;
  assign synth1_m_bypass   = div_reg.m_bypass;

  // ========================================================================
  // Reference selection and secondary buffer control
  refin_pkg::sec_buf_state_e sb_reg, sb_next;
  logic                      sel_sec_reg, sel_sec_next;
  logic                      auto_sel_sec;

  // Primary wins whenever it is alive; secondary only covers a loss
  assign auto_sel_sec = !pri_ok && sec_ok;

  always_comb begin
    case (src_reg)
      refin_pkg::SRC_AUTO: sel_sec_next = auto_sel_sec;
      refin_pkg::SRC_PIN:  sel_sec_next = pin_sel && auto_sel_sec;
      refin_pkg::SRC_PRI:  sel_sec_next = 1'b0;
      default:             sel_sec_next = 1'b1;
    endcase
    sb_next = sb_reg;
    case (sb_reg)
      refin_pkg::SB_ON_SEC: begin
        if (!sel_sec_reg) begin
          sb_next = refin_pkg::SB_BACK;
        end
      end
      default: begin
        if (sel_sec_reg) begin
          sb_next = refin_pkg::SB_ON_SEC;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sb_reg      <= refin_pkg::SB_STANDBY;
      sel_sec_reg <= 1'b0;
    end else begin
      sb_reg      <= sb_next;
      sel_sec_reg <= sel_sec_next;
    end
  end

  assign ref_sel_secondary = sel_sec_reg;
  // Off only after a return to primary; the standby phase keeps it up
  // so that a primary loss can still be covered
  assign sec_buf_en = (sb_reg != refin_pkg::SB_BACK) ||
                      icc_reg.sec_buf_keep_on;

  // ========================================================================
  // AXI4-Lite read channel
  logic        rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0]  rresp_reg, rresp_next;
  logic        ar_hs;

  assign s_axi_arready = !rvalid_reg;
  assign ar_hs         = s_axi_arvalid && s_axi_arready;

  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (ar_hs) begin
      rvalid_next = 1'b1;
      rresp_next  = `RESP_OKAY;
      rdata_next  = 32'h0;
      if (addr_is(s_axi_araddr, `IDX_ICC)) begin
        rdata_next[7:0] = icc_reg;
      end else if (addr_is(s_axi_araddr, `IDX_RDIV)) begin
        rdata_next[`RDIV_MSB:0] = rdiv_reg;
      end else if (addr_is(s_axi_araddr, `IDX_MDIV)) begin
        rdata_next[`MDIV_MSB:0] = mdiv_reg;
      end else if (addr_is(s_axi_araddr, `IDX_SRC_SEL)) begin
        rdata_next[`SRC_MSB:0] = src_reg;
      end else if (addr_is(s_axi_araddr, `IDX_STATUS)) begin
        rdata_next[5:0] = {sec_ok, pri_ok, sb_reg,
                           sec_buf_en, sel_sec_reg};
      end else begin
        rresp_next = `RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0;
      rresp_reg  <= `RESP_OKAY;
    end else begin
      rvalid_reg <= rvalid_next;
      rdata_reg  <= rdata_next;
      rresp_reg  <= rresp_next;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

  // ========================================================================
  // Assertions
  sequence return_to_primary;
    sb_reg == refin_pkg::SB_ON_SEC ##1 sb_reg == refin_pkg::SB_BACK;
  endsequence

  AST_MUX_BYPASS: assert property (icc_wr |=>
    ref_mux_bypass == $past(wr_data[`ICC_MUX_BYP]))
    else $error("mux bypass does not follow write");
  AST_SEC_OFF: assert property (return_to_primary ##0
    !icc_reg.sec_buf_keep_on |-> !sec_buf_en)
    else $error("secondary buffer left on after return");
  AST_SEC_KEEP: assert property (return_to_primary ##0
    icc_reg.sec_buf_keep_on |-> sec_buf_en)
    else $error("secondary buffer dropped despite keep-on");
  AST_SEC_GAIN: assert property (icc_wr |=>
    sec_buf_gain_max == $past(wr_data[`ICC_SEC_GAIN]))
    else $error("secondary gain does not follow write");
  AST_PRI_GAIN: assert property (icc_wr |=>
    pri_buf_gain_max == $past(wr_data[`ICC_PRI_GAIN]))
    else $error("primary gain does not follow write");
  AST_RDIV_MAX: assert property (rdiv_wr &&
    wr_data[`RDIV_MSB:0] == 3'h7 |=> synth1_ref_ratio == 4'h8 &&
    !synth1_ref_bypass)
    else $error("R divider code 7 is not divide by 8");
  AST_MDIV_RATIO: assert property (mdiv_wr |=>
    synth1_m_bypass == ($past(wr_data[`MDIV_MSB:0]) == 5'h00) &&
    synth1_m_ratio == (synth1_m_bypass ? 6'h01 :
      ({1'b0, $past(wr_data[`MDIV_MSB:0])} + 6'h01)))
    else $error("M divider ratio wrong");
  AST_AUTO_PRI: assert property (src_reg == refin_pkg::SRC_AUTO &&
    pri_ok |=> !ref_sel_secondary)
    else $error("auto mode left primary while it is alive");
  AST_WR_RESP: assert property (do_write |=> s_axi_bvalid && !s_axi_awready)
    else $error("write response missing");

endmodule // ref_input_and_synth1_divider_regs

// ==== tb/ref_input_and_synth1_divider_regs_tb.sv ====
`timescale 1ns/1ps
`include "refin_cfg.svh"

module ref_input_and_synth1_divider_regs_tb;

  // ==========================================================================
  // Signals
  logic                 aclk;
  logic                 aresetn;
  logic [`ADDR_W-1:0]   s_axi_awaddr;
  logic                 s_axi_awvalid;
  logic                 s_axi_awready;
  logic [31:0]          s_axi_wdata;
  logic [3:0]           s_axi_wstrb;
  logic                 s_axi_wvalid;
  logic                 s_axi_wready;
  logic [1:0]           s_axi_bresp;
  logic                 s_axi_bvalid;
  logic                 s_axi_bready;
  logic [`ADDR_W-1:0]   s_axi_araddr;
  logic                 s_axi_arvalid;
  logic                 s_axi_arready;
  logic [31:0]          s_axi_rdata;
  logic [1:0]           s_axi_rresp;
  logic                 s_axi_rvalid;
  logic                 s_axi_rready;
  logic                 pri_clk_present;
  logic                 sec_clk_present;
  logic                 ref_select_pin;
  logic                 ref_mux_bypass;
  logic                 sec_buf_en;
  logic                 sec_buf_gain_max;
  logic                 pri_buf_gain_max;
  logic                 ref_sel_secondary;
  logic [3:0]           synth1_ref_ratio;
  logic                 synth1_ref_bypass;
  logic [5:0]           synth1_m_ratio;
  logic                 synth1_m_bypass;
  int                   n_mismatch = 0;
  int                   n_compared = 0;
  logic [31:0]          rd;
  logic [1:0]           resp;
  logic [7:0]           icc_val [5] = '{8'h80, 8'h04, 8'h02, 8'h01, 8'h78};

  ref_input_and_synth1_divider_regs u_ref_input_and_synth1_divider_regs (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .pri_clk_present(pri_clk_present),
    .sec_clk_present(sec_clk_present), .ref_select_pin(ref_select_pin),
    .ref_mux_bypass(ref_mux_bypass), .sec_buf_en(sec_buf_en),
    .sec_buf_gain_max(sec_buf_gain_max),
    .pri_buf_gain_max(pri_buf_gain_max),
    .ref_sel_secondary(ref_sel_secondary),
    .synth1_ref_ratio(synth1_ref_ratio),
    .synth1_ref_bypass(synth1_ref_bypass),
    .synth1_m_ratio(synth1_m_ratio), .synth1_m_bypass(synth1_m_bypass));

  // ==========================================================================
  // Helpers
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [31:0] ratio_of(input int code);
    return (code == 0) ? 32'h1 : 32'(code + 1);
  endfunction

  // Samples at the falling edge so the handshake seen is the one the
  // next rising edge will take, whatever order the simulator runs in
  task automatic axi_write(input logic [9:0] a, input logic [31:0] d,
                           input logic [3:0] strb, output logic [1:0] br);
    logic aw_done;
    logic w_done;
    int   g;
    aw_done = 1'b0;
    w_done  = 1'b0;
    g       = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= strb;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(aw_done && w_done) && g < 50) begin
      @(negedge aclk);
      if (s_axi_awvalid && s_axi_awready) aw_done = 1'b1;
      if (s_axi_wvalid && s_axi_wready) w_done = 1'b1;
      @(posedge aclk);
      if (aw_done) s_axi_awvalid <= 1'b0;
      if (w_done) s_axi_wvalid <= 1'b0;
      g++;
    end
    do @(negedge aclk); while (!s_axi_bvalid && ++g < 100);
    if (!s_axi_bvalid) n_mismatch++;
    br = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    @(negedge aclk);
  endtask

  task automatic axi_read(input logic [9:0] a, output logic [31:0] d,
                          output logic [1:0] rr);
    int g;
    g = 0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready && ++g < 50);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_rvalid && ++g < 100);
    if (!s_axi_rvalid) n_mismatch++;
    d  = s_axi_rdata;
    rr = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    @(negedge aclk);
  endtask

  // Synchroniser plus selection register needs three edges; five is slack
  task automatic set_pri(input logic v);
    @(posedge aclk);
    pri_clk_present <= v;
    repeat (5) @(negedge aclk);
  endtask

  task automatic tally_and_finish;
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================================
  // Watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    tally_and_finish();
  end

  // ==========================================================================
  // Tests
  initial begin
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {pri_clk_present, sec_clk_present, ref_select_pin} = 3'h7;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    check("bypass_rst", ref_mux_bypass, 32'h0);
    check("sec_gain_rst", sec_buf_gain_max, 32'h1);
    check("pri_gain_rst", pri_buf_gain_max, 32'h1);
    axi_read(`BYTE_ADDR(`IDX_ICC), rd, resp);
    check("icc_rst", rd, 32'h3);
    axi_read(`BYTE_ADDR(`IDX_RDIV), rd, resp);
    check("rdiv_rst", rd, 32'h0);
    axi_read(`BYTE_ADDR(`IDX_MDIV), rd, resp);
    check("mdiv_rst", rd, 32'h0);
    foreach (icc_val[i]) begin
      axi_write(`BYTE_ADDR(`IDX_ICC), {24'hFFFFFF, icc_val[i]}, 4'hF, resp);
      check("icc_bresp", resp, `RESP_OKAY);
      axi_read(`BYTE_ADDR(`IDX_ICC), rd, resp);
      check("icc_rresp", resp, `RESP_OKAY);
      check("icc_read", rd, {24'h0, icc_val[i]});
      check("bypass", ref_mux_bypass, icc_val[i][7]);
      check("sec_gain", sec_buf_gain_max, icc_val[i][1]);
      check("pri_gain", pri_buf_gain_max, icc_val[i][0]);
    end
    for (int c = 0; c < 8; c++) begin
      axi_write(`BYTE_ADDR(`IDX_RDIV), 32'hFFFFFFF8 | c, 4'hF, resp);
      axi_read(`BYTE_ADDR(`IDX_RDIV), rd, resp);
      check("rdiv_read", rd, c);
      check("ref_ratio", synth1_ref_ratio, ratio_of(c));
      check("ref_bypass", synth1_ref_bypass, c == 0);
    end
    for (int c = 0; c < 32; c++) begin
      axi_write(`BYTE_ADDR(`IDX_MDIV), 32'hFFFFFFE0 | c, 4'hF, resp);
      axi_read(`BYTE_ADDR(`IDX_MDIV), rd, resp);
      check("mdiv_read", rd, c);
      check("m_ratio", synth1_m_ratio, ratio_of(c));
      check("m_bypass", synth1_m_bypass, c == 0);
    end
    // Lane 0 disabled must leave the field alone
    axi_write(`BYTE_ADDR(`IDX_MDIV), 32'h5, 4'hE, resp);
    axi_read(`BYTE_ADDR(`IDX_MDIV), rd, resp);
    check("mdiv_nostrb", rd, 32'h1F);
    axi_write(10'h100, 32'h1, 4'hF, resp);
    check("unmapped_bresp", resp, `RESP_SLVERR);
    axi_read(10'h100, rd, resp);
    check("unmapped_rresp", resp, `RESP_SLVERR);
    check("unmapped_rdata", rd, 32'h0);
    // Automatic selection, keep-on cleared and then set
    axi_write(`BYTE_ADDR(`IDX_ICC), 32'h3, 4'hF, resp);
    axi_write(`BYTE_ADDR(`IDX_SRC_SEL), 32'h0, 4'hF, resp);
    repeat (5) @(negedge aclk);
    check("sel_auto_pri", ref_sel_secondary, 32'h0);
    check("buf_standby", sec_buf_en, 32'h1);
    set_pri(1'b0);
    check("sel_auto_sec", ref_sel_secondary, 32'h1);
    check("buf_on_sec", sec_buf_en, 32'h1);
    set_pri(1'b1);
    check("sel_back", ref_sel_secondary, 32'h0);
    check("buf_off_back", sec_buf_en, 32'h0);
    axi_write(`BYTE_ADDR(`IDX_ICC), 32'h7, 4'hF, resp);
    check("buf_keep", sec_buf_en, 32'h1);
    set_pri(1'b0);
    set_pri(1'b1);
    check("buf_keep_back", sec_buf_en, 32'h1);
    // A dead secondary must not be chosen either
    @(posedge aclk);
    sec_clk_present <= 1'b0;
    set_pri(1'b0);
    check("sel_no_sec", ref_sel_secondary, 32'h0);
    // Forced and pin-driven selection modes
    axi_write(`BYTE_ADDR(`IDX_SRC_SEL), 32'h3, 4'hF, resp);
    check("sel_forced_sec", ref_sel_secondary, 32'h1);
    @(posedge aclk);
    sec_clk_present <= 1'b1;
    axi_write(`BYTE_ADDR(`IDX_SRC_SEL), 32'h2, 4'hF, resp);
    check("sel_forced_pri", ref_sel_secondary, 32'h0);
    axi_write(`BYTE_ADDR(`IDX_SRC_SEL), 32'h1, 4'hF, resp);
    check("sel_pin_auto", ref_sel_secondary, 32'h1);
    @(posedge aclk);
    ref_select_pin <= 1'b0;
    repeat (5) @(negedge aclk);
    check("sel_pin_pri", ref_sel_secondary, 32'h0);
    tally_and_finish();
  end

endmodule // ref_input_and_synth1_divider_regs_tb
